// ===== dv/dsk_cmd_port_tb_top.sv
// Purpose: Self-checking bench of the drive-side command port
// Assumes: Unit address 2, revolution of 720 cycles
// Notes:   One task per scenario
`timescale 1ns/100ps
`default_nettype none
module dsk_cmd_port_tb_top;
	localparam int REV = 720;
	// ------
	// Signals
	// ------
	logic        ref_clk, rst, write_gate, read_gate, osc_clk, osc_lock, rd_raw;
	logic [2:0]  unit_sel, unit_addr, head_num, strobe_ofs, track_ofs;
	logic [3:0]  head_sel;
	logic        xfer_req, cmd_data, xfer_ack, resp_data, unit_selected;
	logic        cmd_complete, ready, alert, rev_mark, sector_mark, spin_on;
	logic        seek_stb, recal_stb, diag_stb, write_en, rdref_clk, nrz_rd;
	logic [11:0] seek_cyl;
	logic [7:0]  hs_err;
	logic [15:0] seek_n, recal_n, diag_n, cyl_seen;
	int          failures, cmp_count;

	dsk_cmd_port #(.REV_CYC(REV)) i_dsk_cmd_port (
		.ref_clk, .rst, .unit_sel, .unit_addr, .head_sel, .unit_selected,
		.head_num, .xfer_req, .cmd_data, .xfer_ack, .resp_data, .cmd_complete,
		.ready, .alert, .rev_mark, .sector_mark, .spin_on, .seek_stb, .seek_cyl,
		.recal_stb, .diag_stb, .strobe_ofs, .track_ofs, .write_gate, .read_gate,
		.phase_locked_osc_clk(osc_clk), .phase_locked_osc_lock(osc_lock),
		.rd_raw, .write_en, .rdref_clk, .nrz_rd
	);
	dsk_ctl_model i_dsk_ctl_model (
		.ref_clk, .xfer_ack, .resp_data, .xfer_req, .cmd_data, .hs_err
	);

	// 200 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	// Read clock, runs only under read gate
	initial begin
		osc_clk = 1'b0;
		#0.7;
		forever begin
			#32;
			if (read_gate) osc_clk = ~osc_clk;
		end
	end
	// Strobe counters; acknowledge implies command busy
	always @(posedge ref_clk) begin
		if (seek_stb === 1'b1) seek_n <= seek_n + 16'h0001;
		if (seek_stb === 1'b1) cyl_seen <= {4'h0, seek_cyl};
		if (recal_stb === 1'b1) recal_n <= recal_n + 16'h0001;
		if (diag_stb === 1'b1) diag_n <= diag_n + 16'h0001;
		if (xfer_ack === 1'b1) chk_bit(cmd_complete, 1'b0);
	end

	// ------
	// Helpers
	// ------
	task automatic chk_bit(input logic got, input logic exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task automatic wait_cc();
		int n;
		for (n = 0; n < 40 && cmd_complete !== 1'b1; n++) cyc(1);
		chk_bit(cmd_complete, 1'b1);
	endtask : wait_cc
	task automatic wait_rdy();
		int n;
		for (n = 0; n < 1300 && ready !== 1'b1; n++) cyc(1);
		chk_bit(ready, 1'b1);
	endtask : wait_rdy
	task automatic do_cmd(input logic [15:0] w);
		i_dsk_ctl_model.send(w, 1'b0);
		wait_cc();
	endtask : do_cmd
	task automatic do_req(input logic [15:0] w, input logic [15:0] exp);
		logic [15:0] r;
		i_dsk_ctl_model.send(w, 1'b0);
		i_dsk_ctl_model.recv(r);
		chk_word(r, exp);
		wait_cc();
	endtask : do_req
	task automatic stop_test();
		chk_word({8'h00, hs_err}, 16'h0000);
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stop_test

	// ------
	// Scenarios
	// ------
	task automatic t_power();
		cyc(11);
		chk_bit(alert, 1'b1);
		chk_bit(cmd_complete, 1'b0);
		@(posedge ref_clk);
		rst <= 1'b0;
		cyc(500);
		chk_bit(ready, 1'b0);
		wait_rdy();
		wait_cc();
	endtask : t_power
	task automatic t_select();
		int s;
		logic seen;
		for (s = 0; s < 16; s++) begin
			@(posedge ref_clk);
			unit_sel <= s[2:0];
			head_sel <= s[3:0];
			cyc(5);
			chk_bit(unit_selected, s[2:0] == 3'h2);
			chk_word({13'h0000, head_num}, {13'h0000, s[2:0]});
		end
		@(posedge ref_clk);
		unit_sel <= 3'h0;
		cyc(5);
		i_dsk_ctl_model.probe(seen);
		chk_bit(seen, 1'b0);
		chk_bit(cmd_complete, 1'b1);
		@(posedge ref_clk);
		unit_sel <= 3'h2;
		cyc(5);
	endtask : t_select
	task automatic t_status();
		logic [3:0]  sub [9] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
		logic [15:0] val [9] = '{16'h724A, 16'h0236, 16'h0007, 16'h0000, 16'h0200,
			16'h0024, 16'h0000, 16'h0000, 16'h0000};
		int i;
		do_req(16'h2000, 16'h0100);
		do_req(16'h2500, 16'h0000);
		do_cmd(16'h5000);
		chk_bit(alert, 1'b0);
		do_req(16'h2000, 16'h0000);
		for (i = 0; i < 9; i++) do_req({4'h3, sub[i], 8'h00}, val[i]);
	endtask : t_status
	task automatic t_mech();
		logic [15:0] oc [6] = '{16'h6500, 16'h6100, 16'h6200, 16'h7300, 16'h7600, 16'h7000};
		logic [2:0]  oe [6] = '{3'h5, 3'h0, 3'h2, 3'h3, 3'h6, 3'h0};
		int i;
		do_cmd(16'h0123);
		do_cmd(16'h1ABC);
		do_cmd(16'h8000);
		cyc(2);
		chk_word(seek_n, 16'h0001);
		chk_word(cyl_seen, 16'h0123);
		chk_word(recal_n, 16'h0001);
		chk_word(diag_n, 16'h0001);
		for (i = 0; i < 6; i++) begin
			do_cmd(oc[i]);
			chk_word({13'h0000, oc[i][12] ? track_ofs : strobe_ofs}, {13'h0000, oe[i]});
		end
	endtask : t_mech
	task automatic t_fault();
		i_dsk_ctl_model.send(16'h2000, 1'b1);
		wait_cc();
		chk_bit(alert, 1'b1);
		@(posedge ref_clk);
		write_gate <= 1'b1;
		cyc(6);
		chk_bit(write_en, 1'b0);
		@(posedge ref_clk);
		write_gate <= 1'b0;
		cyc(4);
		do_req(16'h2000, 16'h0082);
		do_cmd(16'h5000);
		@(posedge ref_clk);
		write_gate <= 1'b1;
		cyc(6);
		chk_bit(write_en, 1'b1);
		@(posedge ref_clk);
		write_gate <= 1'b0;
		cyc(4);
		// Unknown opcode, then writing over a track offset
		do_cmd(16'h4000);
		chk_bit(alert, 1'b1);
		do_cmd(16'h7200);
		@(posedge ref_clk);
		write_gate <= 1'b1;
		cyc(6);
		chk_bit(write_en, 1'b0);
		@(posedge ref_clk);
		write_gate <= 1'b0;
		cyc(4);
		do_req(16'h2000, 16'h002A);
		do_cmd(16'h7000);
		do_cmd(16'h5000);
		chk_bit(alert, 1'b0);
	endtask : t_fault
	task automatic t_marks();
		int rv, sc, n;
		logic pr, ps, pc;
		rv = 0;
		sc = 0;
		n = 0;
		for (int k = 0; k < 2 * REV; k++) begin
			pr = rev_mark;
			ps = sector_mark;
			pc = rdref_clk;
			cyc(1);
			if (rev_mark && !pr) rv++;
			if (sector_mark && !ps) sc++;
			if (k < 200 && rdref_clk && !pc) n++;
		end
		chk_word(rv[15:0], 16'h0002);
		chk_word(sc[15:0], 16'h0048);
		chk_word(n[15:0], 16'h000A);
	endtask : t_marks
	task automatic t_read();
		int n;
		logic p;
		@(posedge ref_clk);
		read_gate <= 1'b1;
		rd_raw <= 1'b1;
		cyc(40);
		chk_bit(nrz_rd, 1'b0);
		@(posedge ref_clk);
		osc_lock <= 1'b1;
		for (n = 0; n < 60 && nrz_rd !== 1'b1; n++) cyc(1);
		chk_bit(nrz_rd, 1'b1);
		n = 0;
		repeat (640) begin
			p = rdref_clk;
			cyc(1);
			if (rdref_clk && !p) n++;
		end
		chk_bit(n >= 48 && n <= 51, 1'b1);
		@(posedge ref_clk);
		read_gate <= 1'b0;
		osc_lock <= 1'b0;
		cyc(5);
	endtask : t_read
	task automatic t_spindle();
		do_cmd(16'h5200);
		chk_bit(spin_on, 1'b0);
		chk_bit(alert, 1'b1);
		do_cmd(16'h0005);
		cyc(3);
		chk_word(seek_n, 16'h0001);
		do_req(16'h2000, 16'h0210);
		do_cmd(16'h5300);
		chk_bit(spin_on, 1'b1);
		wait_rdy();
		do_cmd(16'h5000);
		chk_bit(alert, 1'b0);
	endtask : t_spindle

	// Main sequence
	initial begin
		rst = 1'b1;
		unit_sel = 3'h2;
		unit_addr = 3'h2;
		head_sel = 4'h0;
		write_gate = 1'b0;
		read_gate = 1'b0;
		osc_lock = 1'b0;
		rd_raw = 1'b0;
		seek_n = 16'h0000;
		recal_n = 16'h0000;
		diag_n = 16'h0000;
		cyl_seen = 16'h0000;
		failures = 0;
		cmp_count = 0;
		t_power();
		t_select();
		t_status();
		t_mech();
		t_fault();
		t_marks();
		t_read();
		t_spindle();
		stop_test();
	end
	// Watchdog, about four times the expected run
	initial begin
		#300000;
		failures++;
		stop_test();
	end
endmodule : dsk_cmd_port_tb_top
`default_nettype wire

// ===== dv/dsk_ctl_model.sv
// Purpose: Controller side of the serial command handshake
// Assumes: Drive answers each request within 40 cycles
// Notes:   Counts stalled handshakes on hs_err
`timescale 1ns/100ps
`default_nettype none
module dsk_ctl_model (
	// Clock
	input  wire logic       ref_clk,
	// Handshake from the drive
	input  wire logic       xfer_ack,
	input  wire logic       resp_data,
	// Handshake to the drive
	output logic            xfer_req,
	output logic            cmd_data,
	output logic [7:0]      hs_err
);
	// Idle link at time zero
	initial begin
		xfer_req = 1'b0;
		cmd_data = 1'b0;
		hs_err = 8'h00;
	end

	// One four-phase bit, data settled a cycle before request
	task automatic bit_xfer(input logic d, output logic r);
		int n;
		@(posedge ref_clk);
		cmd_data <= d;
		@(posedge ref_clk);
		r = resp_data;
		xfer_req <= 1'b1;
		for (n = 0; n < 40 && xfer_ack !== 1'b1; n++) @(posedge ref_clk);
		if (n == 40) hs_err <= hs_err + 8'h01;
		xfer_req <= 1'b0;
		for (n = 0; n < 40 && xfer_ack !== 1'b0; n++) @(posedge ref_clk);
		if (n == 40) hs_err <= hs_err + 8'h01;
		cmd_data <= ~d;
		repeat (3) @(posedge ref_clk);
	endtask : bit_xfer

	// Command word, msb first, then odd parity or its inverse
	task automatic send(input logic [15:0] w, input logic bad);
		logic r;
		int i;
		for (i = 15; i >= 0; i--) bit_xfer(w[i], r);
		bit_xfer(~^w ^ bad, r);
	endtask : send

	// Reply word, msb first
	task automatic recv(output logic [15:0] w);
		int i;
		for (i = 15; i >= 0; i--) bit_xfer(1'b0, w[i]);
	endtask : recv

	// Lone request held high, reports any acknowledge seen
	task automatic probe(output logic seen);
		seen = 1'b0;
		@(posedge ref_clk);
		xfer_req <= 1'b1;
		repeat (12) begin
			@(posedge ref_clk);
			if (xfer_ack !== 1'b0) seen = 1'b1;
		end
		xfer_req <= 1'b0;
		repeat (5) @(posedge ref_clk);
	endtask : probe
endmodule : dsk_ctl_model
`default_nettype wire

// ===== hdl/dsk_cfg.svh
// Purpose: Constants of the drive-side serial command port
// Assumes: 200 MHz ref_clk
// Notes:   Timing counts, command field values, reply words and status bit positions only
`ifndef DSK_CFG_SVH
`define DSK_CFG_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define DSK_CLK_NS      5
`define DSK_REV_NS      16700000
`define DSK_REV_CYC     (`DSK_REV_NS / `DSK_CLK_NS)
`define DSK_SECTORS     36
`define DSK_BIT_NS      100
`define DSK_REF_HALF    (`DSK_BIT_NS / 2 / `DSK_CLK_NS)
`define DSK_MARK_CYC    8
`define DSK_SPIN_CYC    1024
`define DSK_REV_W       22
`define DSK_CMD_BITS    17
// ----------------------------------------
// Command field values
// ----------------------------------------
`define DSK_OP_SEEK     4'h0
`define DSK_OP_RECAL    4'h1
`define DSK_OP_STAT     4'h2
`define DSK_OP_CFG      4'h3
`define DSK_OP_CTRL     4'h5
`define DSK_OP_STROBE   4'h6
`define DSK_OP_TRACK    4'h7
`define DSK_OP_DIAG     4'h8
`define DSK_SUB_CLR     4'h0
`define DSK_SUB_STOP    4'h2
`define DSK_SUB_START   4'h3
`define DSK_SUB_STD     4'h0
// ----------------------------------------
// Reply words
// ----------------------------------------
`define DSK_CFG_WORD    16'h724A
`define DSK_CYLS        16'h0236
`define DSK_HEADS       16'h0007
`define DSK_SPT         16'h0024
`define DSK_BPS         16'h0200
`define DSK_BPT         16'h0000
`define DSK_ISG         16'h0000
`define DSK_SYNC        16'h0000
`define DSK_NUNIQ       16'h0000
// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define DSK_ST_STOP     9
`define DSK_ST_POR      8
`define DSK_ST_PAR      7
`define DSK_ST_IFC      6
`define DSK_ST_INV      5
`define DSK_ST_SEEK     4
`define DSK_ST_WGTO     3
`define DSK_ST_UNIQ     2
`define DSK_ST_WF       1
`endif

// ===== hdl/dsk_cmd_port.sv
// Purpose: Drive-side selection, serial command channel and status outputs
// Assumes: All pin inputs asynchronous to ref_clk, active high inside
// Notes:   Bench read clock runs at 64 ns period
`timescale 1ns/100ps
`default_nettype none
`include "dsk_cfg.svh"

module dsk_cmd_port
	import dsk_pkg::*;
#(
	parameter int REV_CYC = `DSK_REV_CYC
) (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rst,
	// Selection
	input  wire logic [2:0] unit_sel,
	input  wire logic [2:0] unit_addr,
	input  wire logic [3:0] head_sel,
	output logic            unit_selected,
	output logic [2:0]      head_num,
	// Command handshake
	input  wire logic       xfer_req,
	input  wire logic       cmd_data,
	output logic            xfer_ack,
	output logic            resp_data,
	// Drive state
	output logic            cmd_complete,
	output logic            ready,
	output logic            alert,
	output logic            rev_mark,
	output logic            sector_mark,
	// Mechanics
	output logic            spin_on,
	output logic            seek_stb,
	output logic [11:0]     seek_cyl,
	output logic            recal_stb,
	output logic            diag_stb,
	output logic [2:0]      strobe_ofs,
	output logic [2:0]      track_ofs,
	// Data path
	input  wire logic       write_gate,
	input  wire logic       read_gate,
	input  wire logic       phase_locked_osc_clk,
	input  wire logic       phase_locked_osc_lock,
	input  wire logic       rd_raw,
	output logic            write_en,
	output logic            rdref_clk,
	output logic            nrz_rd
);
	localparam int SEC_CYC = REV_CYC / `DSK_SECTORS;

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [16:0] sync1_ff;
	logic [16:0] sync2_ff;
	logic [2:0]  usel_s;
	logic [2:0]  uaddr_s;
	logic [3:0]  head_s;
	logic        req_s;
	logic        cdat_s;
	logic        rg_s;
	logic        wg_s;
	logic        pclk_s;
	logic        lock_s;
	logic        raw_s;

	// Two flops on every pin
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync1_ff <= 17'h00000;
			sync2_ff <= 17'h00000;
		end else begin
			sync1_ff <= {unit_sel, unit_addr, head_sel, xfer_req, cmd_data, read_gate,
				write_gate, phase_locked_osc_clk, phase_locked_osc_lock, rd_raw};
			sync2_ff <= sync1_ff;
		end
	end

	assign {usel_s, uaddr_s, head_s, req_s, cdat_s, rg_s, wg_s, pclk_s, lock_s, raw_s} =
		sync2_ff;

	// ----------------------------------------
	// Selection
	// ----------------------------------------
	logic       usel_ff;
	logic [2:0] head_ff;
	logic       match;

	assign match = (usel_s != 3'h0) && (usel_s == uaddr_s);

	// Unit match and head number
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			usel_ff <= 1'b0;
			head_ff <= 3'h0;
		end else begin
			usel_ff <= match;
			head_ff <= head_s[2:0];
		end
	end

	assign unit_selected = usel_ff;
	assign head_num      = head_ff;

	// ----------------------------------------
	// Handshake sequencer
	// ----------------------------------------
	dsk_state_t  state_ff;
	logic [4:0]  cnt_ff;
	logic [16:0] cmd_ff;
	logic [15:0] rsp_ff;
	logic        ack_ff;
	logic        cc_ff;
	logic        por_done_ff;
	logic [15:0] word;
	logic [3:0]  op;
	logic [3:0]  sub;
	logic        par_ok;
	logic        is_req;
	logic [15:0] reply;
	logic [15:0] status_word;
	logic        ready_ff;
	logic        alert_ff;
	logic [9:1]  st_ff;

	assign word   = cmd_ff[16:1];
	assign op     = word[15:12];
	assign sub    = word[11:8];
	assign par_ok = ^cmd_ff;
	assign is_req = (op == `DSK_OP_STAT) || (op == `DSK_OP_CFG);
	assign status_word = {6'h00, st_ff, 1'b0};

	// Reply word selection
	always_comb begin
		reply = 16'h0000;
		if (op == `DSK_OP_STAT) begin
			reply = (sub == `DSK_SUB_STD) ? status_word : 16'h0000;
		end else begin
			case (sub)
				4'h0:    reply = `DSK_CFG_WORD;
				4'h1:    reply = `DSK_CYLS;
				4'h3:    reply = `DSK_HEADS;
				4'h4:    reply = `DSK_BPT;
				4'h5:    reply = `DSK_BPS;
				4'h6:    reply = `DSK_SPT;
				4'h7:    reply = `DSK_ISG;
				4'h8:    reply = `DSK_SYNC;
				4'h9:    reply = `DSK_NUNIQ;
				default: reply = 16'h0000;
			endcase
		end
	end

	// Four-phase bit exchange, in then out
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_ff <= S_RX_HI;
			cnt_ff   <= 5'h00;
			cmd_ff   <= 17'h00000;
			rsp_ff   <= 16'h0000;
			ack_ff   <= 1'b0;
			cc_ff    <= 1'b0;
		end else begin
			case (state_ff)
				S_RX_HI: begin
					if (cnt_ff == 5'h00 && por_done_ff) begin
						cc_ff <= 1'b1;
					end
					if (usel_ff && req_s) begin
						cmd_ff   <= {cmd_ff[15:0], cdat_s};
						ack_ff   <= 1'b1;
						cc_ff    <= 1'b0;
						cnt_ff   <= cnt_ff + 5'h01;
						state_ff <= S_RX_LO;
					end
				end
				S_RX_LO: begin
					if (!req_s) begin
						ack_ff   <= 1'b0;
						state_ff <= (cnt_ff == 5'(`DSK_CMD_BITS)) ? S_EXEC : S_RX_HI;
					end
				end
				S_EXEC: begin
					cnt_ff <= 5'h00;
					if (par_ok && is_req) begin
						rsp_ff   <= reply;
						state_ff <= S_TX_HI;
					end else begin
						cc_ff    <= 1'b1;
						state_ff <= S_RX_HI;
					end
				end
				S_TX_HI: begin
					if (usel_ff && req_s) begin
						ack_ff   <= 1'b1;
						state_ff <= S_TX_LO;
					end
				end
				S_TX_LO: begin
					if (!req_s) begin
						ack_ff <= 1'b0;
						rsp_ff <= {rsp_ff[14:0], 1'b0};
						cnt_ff <= cnt_ff + 5'h01;
						if (cnt_ff == 5'h0F) begin
							cnt_ff   <= 5'h00;
							cc_ff    <= 1'b1;
							state_ff <= S_RX_HI;
						end else begin
							state_ff <= S_TX_HI;
						end
					end
				end
				default: state_ff <= S_RX_HI;
			endcase
		end
	end

	assign xfer_ack     = ack_ff & usel_ff;
	assign resp_data    = rsp_ff[15];
	assign cmd_complete = cc_ff;

	// ----------------------------------------
	// Command execution
	// ----------------------------------------
	logic        exec;
	logic        ok_op;
	logic        clr_ff;
	logic        spin_ff;
	logic        seek_ff;
	logic        recal_ff;
	logic        diag_ff;
	logic [11:0] cyl_ff;
	logic [2:0]  sofs_ff;
	logic [2:0]  tofs_ff;
	logic        perr_ff;
	logic        inv_ff;
	logic        sflt_ff;

	assign exec  = (state_ff == S_EXEC) && par_ok;
	assign ok_op = ready_ff && !alert_ff;

	// Decode one command per sequence
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			clr_ff   <= 1'b0;
			spin_ff  <= 1'b1;
			seek_ff  <= 1'b0;
			recal_ff <= 1'b0;
			diag_ff  <= 1'b0;
			cyl_ff   <= 12'h000;
			sofs_ff  <= 3'h0;
			tofs_ff  <= 3'h0;
			perr_ff  <= 1'b0;
			inv_ff   <= 1'b0;
			sflt_ff  <= 1'b0;
		end else begin
			clr_ff   <= 1'b0;
			seek_ff  <= 1'b0;
			recal_ff <= 1'b0;
			diag_ff  <= 1'b0;
			inv_ff   <= 1'b0;
			sflt_ff  <= 1'b0;
			perr_ff  <= (state_ff == S_EXEC) && !par_ok;
			if (exec) begin
				case (op)
					`DSK_OP_SEEK: begin
						seek_ff <= ok_op;
						sflt_ff <= !ok_op;
						if (ok_op) begin
							cyl_ff <= word[11:0];
						end
					end
					`DSK_OP_RECAL: begin
						recal_ff <= ok_op;
						sflt_ff  <= !ok_op;
					end
					`DSK_OP_DIAG: diag_ff <= 1'b1;
					`DSK_OP_STAT, `DSK_OP_CFG: begin
						inv_ff <= (op == `DSK_OP_CFG) && (sub == 4'h2 || sub > 4'h9);
					end
					`DSK_OP_CTRL: begin
						case (sub)
							`DSK_SUB_CLR:   clr_ff  <= 1'b1;
							`DSK_SUB_STOP:  spin_ff <= 1'b0;
							`DSK_SUB_START: spin_ff <= 1'b1;
							default:        inv_ff  <= 1'b1;
						endcase
					end
					// Magnitude in bits 10..9, late or minus in bit 8, bit 11 set gives zero
					`DSK_OP_STROBE: sofs_ff <= (sub[3] || sub[2:1] == 2'h0) ?
						3'h0 : {sub[2:1], sub[0]};
					`DSK_OP_TRACK: tofs_ff <= (sub[3] || sub[2:1] == 2'h0) ?
						3'h0 : {sub[2:1], sub[0]};
					default: inv_ff <= 1'b1;
				endcase
			end
		end
	end

	assign spin_on    = spin_ff;
	assign seek_stb   = seek_ff;
	assign seek_cyl   = cyl_ff;
	assign recal_stb  = recal_ff;
	assign diag_stb   = diag_ff;
	assign strobe_ofs = sofs_ff;
	assign track_ofs  = tofs_ff;

	// ----------------------------------------
	// Spindle, status and alert
	// ----------------------------------------
	logic [10:0] spin_cnt_ff;
	logic        spin_d_ff;
	logic        wf_set;
	logic        wgto_set;
	logic [9:1]  st_set;
	logic        wen_ff;

	assign wf_set   = wg_s && !(ready_ff && !alert_ff);
	assign wgto_set = wg_s && (tofs_ff != 3'h0);
	assign st_set   = {!spin_ff, 1'b0, perr_ff, 1'b0, inv_ff, sflt_ff, wgto_set, 1'b0, wf_set};

	// Spin-up timer gives ready
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			spin_cnt_ff <= 11'h000;
			ready_ff    <= 1'b0;
			por_done_ff <= 1'b0;
		end else begin
			if (!spin_ff) begin
				spin_cnt_ff <= 11'h000;
			end else if (spin_cnt_ff != 11'(`DSK_SPIN_CYC)) begin
				spin_cnt_ff <= spin_cnt_ff + 11'h001;
			end
			ready_ff <= spin_ff && (spin_cnt_ff == 11'(`DSK_SPIN_CYC));
			if (ready_ff) begin
				por_done_ff <= 1'b1;
			end
		end
	end

	// Sticky status; a set beats a clear in the same cycle
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_ff     <= 9'h080; // Power-on condition pending
			alert_ff  <= 1'b1;
			spin_d_ff <= 1'b1;
		end else begin
			spin_d_ff <= spin_ff;
			st_ff     <= (clr_ff ? 9'h000 : st_ff) | st_set;
			if ((st_set & ~st_ff) != 9'h000 || spin_d_ff != spin_ff) begin
				alert_ff <= 1'b1;
			end else if (clr_ff) begin
				alert_ff <= 1'b0;
			end
		end
	end

	// Write enable gated by ready, alert and command-complete
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wen_ff <= 1'b0;
		end else begin
			wen_ff <= wg_s && ready_ff && !alert_ff && cc_ff;
		end
	end

	assign ready    = ready_ff;
	assign alert    = alert_ff;
	assign write_en = wen_ff;

	// ----------------------------------------
	// Revolution and sector markers
	// ----------------------------------------
	logic [`DSK_REV_W-1:0] rev_cnt_ff;
	logic [`DSK_REV_W-1:0] sec_cnt_ff;
	logic                  rev_ff;
	logic                  sec_ff;

	// Free-running rotation timers while at speed
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rev_cnt_ff <= '0;
			sec_cnt_ff <= '0;
			rev_ff     <= 1'b0;
			sec_ff     <= 1'b0;
		end else if (!ready_ff) begin
			rev_cnt_ff <= '0;
			sec_cnt_ff <= '0;
			rev_ff     <= 1'b0;
			sec_ff     <= 1'b0;
		end else begin
			rev_cnt_ff <= (rev_cnt_ff == `DSK_REV_W'(REV_CYC - 1)) ? '0 :
				rev_cnt_ff + `DSK_REV_W'(1);
			sec_cnt_ff <= (sec_cnt_ff == `DSK_REV_W'(SEC_CYC - 1) ||
				rev_cnt_ff == `DSK_REV_W'(REV_CYC - 1)) ? '0 :
				sec_cnt_ff + `DSK_REV_W'(1);
			rev_ff <= rev_cnt_ff < `DSK_REV_W'(`DSK_MARK_CYC);
			sec_ff <= sec_cnt_ff < `DSK_REV_W'(`DSK_MARK_CYC);
		end
	end

	assign rev_mark    = rev_ff;
	assign sector_mark = sec_ff;

	// ----------------------------------------
	// Read/reference clock and read data
	// ----------------------------------------
	logic [3:0] div_ff;
	logic       refc_ff;
	logic       sel_rd_ff;
	logic       oclk_ff;
	logic       pclk_d_ff;
	logic       rd_ff;
	logic       new_src;
	logic       swap;

	assign new_src = rg_s ? pclk_s : refc_ff;
	assign swap    = (rg_s != sel_rd_ff) && !oclk_ff && !new_src;

	// Reference divider, a base for the controller write clock
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_ff  <= 4'h0;
			refc_ff <= 1'b0;
		end else if (div_ff == 4'(`DSK_REF_HALF - 1)) begin
			div_ff  <= 4'h0;
			refc_ff <= !refc_ff;
		end else begin
			div_ff <= div_ff + 4'h1;
		end
	end

	// Swap sources only while both sit low
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sel_rd_ff <= 1'b0;
			oclk_ff   <= 1'b0;
		end else begin
			if (swap) begin
				sel_rd_ff <= rg_s;
			end
			oclk_ff <= swap ? 1'b0 : (sel_rd_ff ? pclk_s : refc_ff);
		end
	end

	// Read data held low until lock, then on read clock rise
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pclk_d_ff <= 1'b0;
			rd_ff     <= 1'b0;
		end else begin
			pclk_d_ff <= pclk_s;
			if (!(rg_s && lock_s)) begin
				rd_ff <= 1'b0;
			end else if (pclk_s && !pclk_d_ff) begin
				rd_ff <= raw_s;
			end
		end
	end

	assign rdref_clk = oclk_ff;
	assign nrz_rd    = rd_ff;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	property p_usel;
		(usel_s == 3'h0) || (usel_s != uaddr_s) |=> !unit_selected;
	endproperty
	a_usel: assert property (p_usel) else $error("unit selected on wrong code");

	property p_head;
		##1 head_num == $past(head_s[2:0]);
	endproperty
	a_head: assert property (p_head) else $error("head number wrong");

	property p_cc_drop;
		(state_ff == S_RX_HI && usel_ff && req_s) |=> !cmd_complete [*2];
	endproperty
	a_cc_drop: assert property (p_cc_drop) else $error("complete not dropped");

	property p_ack_four;
		$rose(xfer_ack) |-> $past(req_s) ##1 (xfer_ack throughout (req_s [*1]));
	endproperty
	a_ack_four: assert property (p_ack_four) else $error("ack without request");

	property p_parity;
		(state_ff == S_EXEC && !par_ok) |=> ##1 st_ff[`DSK_ST_PAR] && alert;
	endproperty
	a_parity: assert property (p_parity) else $error("parity fault missed");

	property p_seek_gate;
		seek_stb |-> $past(ready) && !$past(alert);
	endproperty
	a_seek_gate: assert property (p_seek_gate) else $error("seek while blocked");

	property p_write_gate;
		(alert || !ready) |=> !write_en;
	endproperty
	a_write_gate: assert property (p_write_gate) else $error("write while blocked");

	property p_alert_clr;
		$fell(alert) |-> $past(clr_ff);
	endproperty
	a_alert_clr: assert property (p_alert_clr) else $error("alert fell alone");

	property p_cfg_word;
		(exec && op == `DSK_OP_CFG && sub == 4'h0) |=> rsp_ff == `DSK_CFG_WORD;
	endproperty
	a_cfg_word: assert property (p_cfg_word) else $error("config word wrong");

	property p_rd_hold;
		!lock_s |=> !nrz_rd;
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data before lock");

	property p_rev;
		$rose(rev_mark) |-> $past(rev_cnt_ff) == '0;
	endproperty
	a_rev: assert property (p_rev) else $error("revolution mark misplaced");

endmodule : dsk_cmd_port
`default_nettype wire

// ===== hdl/dsk_pkg.sv
// Purpose: Types of the drive-side serial command port
// Assumes: Nothing
// Notes:   Handshake sequencer states
package dsk_pkg;
	typedef enum logic [2:0] {
		S_RX_HI,
		S_RX_LO,
		S_EXEC,
		S_TX_HI,
		S_TX_LO
	} dsk_state_t;
endpackage : dsk_pkg
